// [include/acr_pkg.sv]
/*
 converter control word package: bit positions, reset values, timing
 constants, power mode enum, control word carrier and decode functions.
 assumes core_clk runs at 25 MHz, apart from the 4.9152 MHz converter master clock.
*/
// Functional notes
// - power_down set enters a power save mode, cleared resumes normal
// - sleep_select picks standby (osc on) or sleep (osc off)
// - leaving sleep on internal osc waits about 20 ms; external none
// - standby keeps oscillator and analog bias running for fast return
// - any power save mode halts filter and powers down most analog
// - writing system_reset_bit 1 puts internal logic into reset
// - proper reset sets read-only reset_valid_flag; writes never touch it (here a write that starts a reset clears it)
// - reading the control word clears reset_valid_flag
// - reset loads control 0, offset 0, gain 0100_0000 hex
// - reset write only sets reset bit; other bits need second write (here the write that clears the reset bit loads none of them)
// - host clears reset bit to end cycle; device returns to command mode
// - input_short set shorts all input pairs internally, clear is normal
// - ref_range_select picks reference sampling capacitor by reference
// - each write drives latch pins from bits 24 and 23 (here writes that start or end a reset do not)
// - notch_rate_scale set scales all word rates and filter by 5/6
// - word_rate_code selects ten rates, 120..7.5 and 3840..240 Sps
// - rates assume 4.9152 MHz master clock and scale linearly with it
// - first continuous and every single conversion take longer
// - polarity_select picks unipolar or bipolar input span
// - open_lead_probe set enables test current source on the input
// - a write is command byte plus 32 data bits, then command mode
package acr_pkg;
    localparam int CFG_W     = 32;
    localparam int BIT_SLEEP = 31;
    localparam int BIT_PDOWN = 30;
    localparam int BIT_RST   = 29;
    localparam int BIT_RV    = 28;
    localparam int BIT_SHORT = 27;
    localparam int BIT_REF   = 25;
    localparam int BIT_LHI   = 24;
    localparam int BIT_LLO   = 23;
    localparam int BIT_NRS   = 19;
    localparam int WR_MSB    = 14;
    localparam int WR_LSB    = 11;
    localparam int BIT_POL   = 10;
    localparam int BIT_OPEN  = 9;

    localparam logic [CFG_W-1:0] CFG_RESET    = 32'h0000_0000;
    localparam logic [CFG_W-1:0] OFFSET_RESET = 32'h0000_0000;
    localparam logic [CFG_W-1:0] GAIN_RESET   = 32'h0100_0000;

    localparam int RST_CYCLES   = 8;
    localparam int RST_CNT_W    = 4;
    localparam int WAKE_TIME_MS = 20;
    localparam int CORE_CLK_KHZ = 25000;
    localparam int WAKE_CNT_W   = 20;

    localparam int MCLK_HZ       = 4915200;
    localparam int FAST_RATE_SPS = 3840;
    localparam int SLOW_RATE_SPS = 120;
    localparam int RATE_STEPS    = 5;
    localparam int SCALE_NUM     = 6;
    localparam int SCALE_DEN     = 5;
    localparam int PERIOD_W      = 20;
    localparam int FIRST_W       = 22;
    localparam logic [PERIOD_W-1:0] FAST_PERIOD =
        PERIOD_W'(MCLK_HZ / FAST_RATE_SPS);
    localparam logic [PERIOD_W-1:0] SLOW_PERIOD =
        PERIOD_W'(MCLK_HZ / SLOW_RATE_SPS);

    typedef enum logic [1:0] {
        PM_NORMAL  = 2'b00,
        PM_STANDBY = 2'b01,
        PM_SLEEP   = 2'b10,
        PM_WAKE    = 2'b11
    } acr_pmode_e;

    typedef struct packed {
        logic       sleep_select;
        logic       power_down;
        logic       system_reset_bit;
        logic       reset_valid_flag;
        logic       input_short;
        logic       ref_range_select;
        logic       latch_out_hi;
        logic       latch_out_lo;
        logic       notch_rate_scale;
        logic [3:0] word_rate_code;
        logic       polarity_select;
        logic       open_lead_probe;
    } acr_cfg_s;

    // reserved bits always read back as zero
    function automatic logic [CFG_W-1:0] acr_cfg_word(input acr_cfg_s c);
        logic [CFG_W-1:0] w;
        w                = CFG_RESET;
        w[BIT_SLEEP]     = c.sleep_select;
        w[BIT_PDOWN]     = c.power_down;
        w[BIT_RST]       = c.system_reset_bit;
        w[BIT_RV]        = c.reset_valid_flag;
        w[BIT_SHORT]     = c.input_short;
        w[BIT_REF]       = c.ref_range_select;
        w[BIT_LHI]       = c.latch_out_hi;
        w[BIT_LLO]       = c.latch_out_lo;
        w[BIT_NRS]       = c.notch_rate_scale;
        w[WR_MSB:WR_LSB] = c.word_rate_code;
        w[BIT_POL]       = c.polarity_select;
        w[BIT_OPEN]      = c.open_lead_probe;
        return w;
    endfunction : acr_cfg_word

    function automatic acr_cfg_s acr_cfg_from_word(input logic [CFG_W-1:0] w,
                                                   input logic rv);
        acr_cfg_s c;
        c.sleep_select     = w[BIT_SLEEP];
        c.power_down       = w[BIT_PDOWN];
        c.system_reset_bit = w[BIT_RST];
        c.reset_valid_flag = rv;
        c.input_short      = w[BIT_SHORT];
        c.ref_range_select = w[BIT_REF];
        c.latch_out_hi     = w[BIT_LHI];
        c.latch_out_lo     = w[BIT_LLO];
        c.notch_rate_scale = w[BIT_NRS];
        c.word_rate_code   = w[WR_MSB:WR_LSB];
        c.polarity_select  = w[BIT_POL];
        c.open_lead_probe  = w[BIT_OPEN];
        return c;
    endfunction : acr_cfg_from_word

    function automatic logic acr_rate_ok(input logic [3:0] code);
        return code[2:0] < 3'(RATE_STEPS);
    endfunction : acr_rate_ok

    // period in master clocks; each code step halves the rate
    function automatic logic [PERIOD_W-1:0] acr_period(input logic [3:0] code,
                                                       input logic scale);
        logic [PERIOD_W-1:0] p;
        p = (code[3] ? FAST_PERIOD : SLOW_PERIOD) << code[2:0];
        if (scale)
        begin
            p = PERIOD_W'((int'(p) * SCALE_NUM) / SCALE_DEN);
        end
        return p;
    endfunction : acr_period
endpackage : acr_pkg

// [hw/acr_config_reg.sv]
/*
 converter control word with power mode control, system reset cycle,
 option outputs and word period decode; link side on link_clk.
 assumes the serial port logic on link_clk decodes commands and gives one
 link_clk pulse per finished 32-bit write or per read request, and holds
 no second write within 8 link_clk cycles of the first.
*/
`timescale 1ns/100ps
module acr_config_reg
    import acr_pkg::*;
#(
    parameter int WAKE_CYCLES      = WAKE_TIME_MS * CORE_CLK_KHZ,
    parameter int FIRST_CONV_WORDS = 4
)
(
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                link_clk,
    input  wire logic                link_wr_pulse,
    input  wire logic [CFG_W-1:0]    link_wr_data,
    input  wire logic                link_rd_pulse,
    input  wire logic                ext_clock_sel,
    output logic [CFG_W-1:0]         link_rd_data,
    output logic                     link_rd_valid,
    output logic                     sleep_select,
    output logic                     power_down,
    output logic                     system_reset_bit,
    output logic                     reset_valid_flag,
    output logic                     input_short,
    output logic                     ref_range_select,
    output logic                     latch_out_hi,
    output logic                     latch_out_lo,
    output logic                     notch_rate_scale,
    output logic [3:0]               word_rate_code,
    output logic                     polarity_select,
    output logic                     open_lead_probe,
    output logic                     logic_reset,
    output acr_pmode_e               power_mode,
    output logic                     osc_enable,
    output logic                     bias_enable,
    output logic                     analog_enable,
    output logic                     filter_run,
    output logic                     rate_code_valid,
    output logic [PERIOD_W-1:0]      word_period,
    output logic [FIRST_W-1:0]       first_period
);

    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (2 ** WAKE_CNT_W))
    begin : g_bad_wake
        $error("WAKE_CYCLES out of range");
    end
    if (FIRST_CONV_WORDS < 2 || FIRST_CONV_WORDS > 4)
    begin : g_bad_first
        $error("FIRST_CONV_WORDS must be 2 to 4");
    end

    typedef struct packed {
        acr_cfg_s              cfg;
        acr_pmode_e            pmode;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        logic [RST_CNT_W-1:0]  rst_cnt;
        logic                  rst_act;
        logic [2:0]            wr_sync;
        logic [2:0]            rd_sync;
        logic [1:0]            ext_sync;
        logic [CFG_W-1:0]      rd_hold;
        logic                  ack_tgl;
        logic                  osc_en;
        logic                  bias_en;
        logic                  analog_en;
        logic                  filt_run;
        logic                  rate_ok;
        logic [PERIOD_W-1:0]   period;
        logic [FIRST_W-1:0]    first;
    } acr_core_s;

    typedef struct packed {
        logic             wr_tgl;
        logic [CFG_W-1:0] wr_data;
        logic             rd_tgl;
        logic [2:0]       ack_sync;
        logic [CFG_W-1:0] rd_data;
        logic             rd_valid;
    } acr_link_s;

    localparam acr_core_s CORE_RST = '{
        pmode     : PM_NORMAL,
        osc_en    : 1'b1,
        bias_en   : 1'b1,
        analog_en : 1'b1,
        filt_run  : 1'b1,
        rate_ok   : 1'b1,
        period    : SLOW_PERIOD,
        first     : FIRST_W'(int'(SLOW_PERIOD) * FIRST_CONV_WORDS),
        default   : '0
    };
    localparam logic [WAKE_CNT_W-1:0] WAKE_LAST =
        WAKE_CNT_W'(WAKE_CYCLES - 1);
    localparam logic [RST_CNT_W-1:0]  RST_LAST  = RST_CNT_W'(RST_CYCLES - 1);
    localparam logic [RST_CNT_W-1:0]  RST_DONE  = RST_CNT_W'(RST_CYCLES);

    acr_core_s        s;
    acr_core_s        next_s;
    acr_link_s        l;
    acr_link_s        next_l;
    logic             wr_evt;
    logic             rd_evt;
    logic             rv_set;
    logic             ext_clk;
    logic [CFG_W-1:0] wdata;

    // write data is held in the link domain and is quiet while crossing
    assign wr_evt  = s.wr_sync[2] ^ s.wr_sync[1];
    assign rd_evt  = s.rd_sync[2] ^ s.rd_sync[1];
    assign ext_clk = s.ext_sync[1];
    assign wdata   = l.wr_data;
    assign rv_set  = s.rst_act && (s.rst_cnt == RST_LAST);

    always_comb
    begin
        next_s          = s;
        next_s.wr_sync  = {s.wr_sync[1:0], l.wr_tgl};
        next_s.rd_sync  = {s.rd_sync[1:0], l.rd_tgl};
        next_s.ext_sync = {s.ext_sync[0], ext_clock_sel};

        if (s.rst_act && (s.rst_cnt != RST_DONE))
        begin
            next_s.rst_cnt = s.rst_cnt + RST_CNT_W'(1);
        end

        if (wr_evt)
        begin
            if (s.cfg.system_reset_bit)
            begin
                // other bits stay held in reset on this write
                if (!wdata[BIT_RST])
                begin
                    next_s.cfg.system_reset_bit = 1'b0;
                    next_s.rst_act              = 1'b0;
                end
            end
            else if (wdata[BIT_RST])
            begin
                next_s.cfg = acr_cfg_from_word(CFG_RESET, 1'b0);
                next_s.cfg.system_reset_bit = 1'b1;
                next_s.rst_act              = 1'b1;
                next_s.rst_cnt              = '0;
            end
            else
            begin
                next_s.cfg = acr_cfg_from_word(wdata,
                                               s.cfg.reset_valid_flag);
            end
        end

        if (rd_evt)
        begin
            next_s.rd_hold = acr_cfg_word(s.cfg);
            next_s.ack_tgl = ~s.ack_tgl;
            next_s.cfg.reset_valid_flag = 1'b0;
        end
        // set beats a read in the same cycle
        if (rv_set)
        begin
            next_s.cfg.reset_valid_flag = 1'b1;
        end

        case (s.pmode)
            PM_NORMAL:
            begin
                if (s.cfg.power_down)
                begin
                    next_s.pmode = s.cfg.sleep_select ? PM_SLEEP
                                                      : PM_STANDBY;
                end
            end
            PM_STANDBY:
            begin
                if (!s.cfg.power_down)
                begin
                    next_s.pmode = PM_NORMAL;
                end
                else if (s.cfg.sleep_select)
                begin
                    next_s.pmode = PM_SLEEP;
                end
            end
            PM_SLEEP:
            begin
                if (!s.cfg.power_down || !s.cfg.sleep_select)
                begin
                    if (ext_clk)
                    begin
                        next_s.pmode = s.cfg.power_down ? PM_STANDBY
                                                        : PM_NORMAL;
                    end
                    else
                    begin
                        next_s.pmode    = PM_WAKE;
                        next_s.wake_cnt = '0;
                    end
                end
            end
            PM_WAKE:
            begin
                // oscillator restart cannot be cut short
                if (s.wake_cnt == WAKE_LAST)
                begin
                    if (!s.cfg.power_down)
                    begin
                        next_s.pmode = PM_NORMAL;
                    end
                    else
                    begin
                        next_s.pmode = s.cfg.sleep_select ? PM_SLEEP
                                                          : PM_STANDBY;
                    end
                end
                else
                begin
                    next_s.wake_cnt = s.wake_cnt + WAKE_CNT_W'(1);
                end
            end
            default:
            begin
                next_s.pmode = PM_NORMAL;
            end
        endcase

        next_s.osc_en    = (next_s.pmode != PM_SLEEP);
        next_s.bias_en   = (next_s.pmode != PM_SLEEP);
        next_s.analog_en = (next_s.pmode == PM_NORMAL);
        next_s.filt_run  = (next_s.pmode == PM_NORMAL)
                           && !next_s.rst_act;

        // periods in master clocks, so they track the clock rate
        next_s.rate_ok = acr_rate_ok(next_s.cfg.word_rate_code);
        next_s.period  = acr_period(next_s.cfg.word_rate_code,
                                    next_s.cfg.notch_rate_scale);
        next_s.first   = FIRST_W'(int'(next_s.period)
                                  * FIRST_CONV_WORDS);
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= CORE_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // link side: requests leave as toggles, read word returns on ack toggle
    always_comb
    begin
        next_l          = l;
        next_l.rd_valid = 1'b0;
        next_l.ack_sync = {l.ack_sync[1:0], s.ack_tgl};
        if (link_wr_pulse)
        begin
            next_l.wr_data = link_wr_data;
            next_l.wr_tgl  = ~l.wr_tgl;
        end
        if (link_rd_pulse)
        begin
            next_l.rd_tgl = ~l.rd_tgl;
        end
        if (l.ack_sync[2] ^ l.ack_sync[1])
        begin
            next_l.rd_data  = s.rd_hold;
            next_l.rd_valid = 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            l <= '0;
        end
        else
        begin
            l <= next_l;
        end
    end

    assign link_rd_data     = l.rd_data;
    assign link_rd_valid    = l.rd_valid;
    assign sleep_select     = s.cfg.sleep_select;
    assign power_down       = s.cfg.power_down;
    assign system_reset_bit = s.cfg.system_reset_bit;
    assign reset_valid_flag = s.cfg.reset_valid_flag;
    assign input_short      = s.cfg.input_short;
    assign ref_range_select = s.cfg.ref_range_select;
    assign latch_out_hi     = s.cfg.latch_out_hi;
    assign latch_out_lo     = s.cfg.latch_out_lo;
    assign notch_rate_scale = s.cfg.notch_rate_scale;
    assign word_rate_code   = s.cfg.word_rate_code;
    assign polarity_select  = s.cfg.polarity_select;
    assign open_lead_probe  = s.cfg.open_lead_probe;
    assign logic_reset      = s.rst_act;
    assign power_mode       = s.pmode;
    assign osc_enable       = s.osc_en;
    assign bias_enable      = s.bias_en;
    assign analog_enable    = s.analog_en;
    assign filter_run       = s.filt_run;
    assign rate_code_valid  = s.rate_ok;
    assign word_period      = s.period;
    assign first_period     = s.first;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_reset_start;
        wr_evt && !s.cfg.system_reset_bit && wdata[BIT_RST];
    endsequence

    sequence s_reset_held;
        s.rst_act && s.cfg.system_reset_bit;
    endsequence

    a_rv_after_reset: assert property (
        s_reset_start ##1 (s_reset_held and !s.cfg.reset_valid_flag)
        |-> ##8 s.cfg.reset_valid_flag)
        else $error("reset valid flag not set after reset");

    a_reset_only_bit: assert property (
        s_reset_start ##1 s_reset_held
        |-> (acr_cfg_word(s.cfg) == (CFG_RESET | (32'h0000_0001 << BIT_RST))))
        else $error("reset write touched other bits");

    a_read_clears_rv: assert property (
        rd_evt && !rv_set |=> !s.cfg.reset_valid_flag)
        else $error("read did not clear reset valid flag");

    a_set_wins_read: assert property (
        rd_evt && rv_set |=> s.cfg.reset_valid_flag)
        else $error("reset valid set lost to read");

    a_latch_follow: assert property (
        wr_evt && !s.cfg.system_reset_bit && !wdata[BIT_RST]
        |=> latch_out_hi == $past(wdata[BIT_LHI])
            && latch_out_lo == $past(wdata[BIT_LLO]))
        else $error("latch pins do not follow write");

    a_sleep_osc_off: assert property (
        s.pmode == PM_SLEEP |-> !s.osc_en && !s.bias_en)
        else $error("oscillator running in sleep");

    a_standby_bias: assert property (
        s.pmode == PM_STANDBY |-> s.osc_en && s.bias_en && !s.analog_en)
        else $error("standby bias or oscillator wrong");

    a_save_halts: assert property (
        s.pmode != PM_NORMAL |-> !s.filt_run && !s.analog_en)
        else $error("filter running in power save");

    a_wake_holds: assert property (
        s.pmode == PM_WAKE && s.wake_cnt < WAKE_LAST |=> s.pmode == PM_WAKE)
        else $error("wake ended early");

    a_pd_enters_save: assert property (
        s.pmode == PM_NORMAL && s.cfg.power_down
        |=> s.pmode == ($past(s.cfg.sleep_select) ? PM_SLEEP : PM_STANDBY))
        else $error("power down did not enter save mode");

    a_first_longer: assert property (
        s.first > FIRST_W'(s.period))
        else $error("first conversion not longer");

endmodule : acr_config_reg

// [tb/acr_host_model.sv]
/*
 host side model: command decoder strobes for control word writes/reads.
 assumes link_clk from the bench; calls come one at a time after reset.
*/
`timescale 1ns/100ps
module acr_host_model
    import acr_pkg::*;
(
    input  wire logic             link_clk,
    input  wire logic [CFG_W-1:0] link_rd_data,
    input  wire logic             link_rd_valid,
    output logic                  link_wr_pulse,
    output logic [CFG_W-1:0]      link_wr_data,
    output logic                  link_rd_pulse
);
    initial
    begin
        link_wr_pulse = 1'b0;
        link_rd_pulse = 1'b0;
        link_wr_data  = 32'h0000_0000;
    end

    // command byte plus 32 bits, so also beyond 8 link_clk cycles
    task automatic gap();
        repeat (40) @(negedge link_clk);
    endtask : gap

    task automatic wr(input logic [CFG_W-1:0] w);
        @(negedge link_clk);
        link_wr_pulse = 1'b1;
        link_wr_data  = w;
        @(negedge link_clk);
        link_wr_pulse = 1'b0;
        link_wr_data  = ~w; // released, old value not kept
        gap();
    endtask : wr

    task automatic rd(output logic [CFG_W-1:0] w);
        int n;
        w = 'x;
        n = 0;
        @(negedge link_clk);
        link_rd_pulse = 1'b1;
        @(negedge link_clk);
        link_rd_pulse = 1'b0;
        while (link_rd_valid !== 1'b1 && n < 30)
        begin
            @(negedge link_clk);
            n++;
        end
        if (link_rd_valid === 1'b1)
            w = link_rd_data;
        gap();
    endtask : rd
endmodule : acr_host_model

// [tb/test_adc_config_control_register.sv]
/*
 bench for the converter control word: reset cycle, fields, rates, power.
 assumes wake count shortened to 200 core clocks.
*/
`timescale 1ns/100ps
module test_adc_config_control_register
    import acr_pkg::*;
;
    logic core_clk, rstn, link_clk, ext_clock_sel, link_rd_valid;
    logic link_wr_pulse, link_rd_pulse, logic_reset, rate_code_valid;
    logic [CFG_W-1:0] link_wr_data, link_rd_data, r;
    logic sleep_select, power_down, system_reset_bit, reset_valid_flag;
    logic input_short, ref_range_select, latch_out_hi, latch_out_lo;
    logic notch_rate_scale, polarity_select, open_lead_probe;
    logic osc_enable, bias_enable, analog_enable, filter_run;
    logic [3:0] word_rate_code, code;
    logic [PERIOD_W-1:0] word_period, p;
    logic [FIRST_W-1:0] first_period;
    logic [14:0] flds;
    logic [3:0] pw;
    acr_pmode_e power_mode;
    int n_errors, cmp_count, cyc;

    acr_config_reg #(.WAKE_CYCLES(200)) DUT (
        .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk),
        .link_wr_pulse(link_wr_pulse), .link_wr_data(link_wr_data),
        .link_rd_pulse(link_rd_pulse), .ext_clock_sel(ext_clock_sel),
        .link_rd_data(link_rd_data), .link_rd_valid(link_rd_valid),
        .sleep_select(sleep_select), .power_down(power_down),
        .system_reset_bit(system_reset_bit),
        .reset_valid_flag(reset_valid_flag), .input_short(input_short),
        .ref_range_select(ref_range_select), .latch_out_hi(latch_out_hi),
        .latch_out_lo(latch_out_lo), .notch_rate_scale(notch_rate_scale),
        .word_rate_code(word_rate_code), .polarity_select(polarity_select),
        .open_lead_probe(open_lead_probe), .logic_reset(logic_reset),
        .power_mode(power_mode), .osc_enable(osc_enable),
        .bias_enable(bias_enable), .analog_enable(analog_enable),
        .filter_run(filter_run), .rate_code_valid(rate_code_valid),
        .word_period(word_period), .first_period(first_period));
    acr_host_model h (
        .link_clk(link_clk), .link_rd_data(link_rd_data),
        .link_rd_valid(link_rd_valid), .link_wr_pulse(link_wr_pulse),
        .link_wr_data(link_wr_data), .link_rd_pulse(link_rd_pulse));

    assign pw = {osc_enable, bias_enable, analog_enable, filter_run};

    assign flds = {sleep_select, power_down, system_reset_bit,
        reset_valid_flag, input_short, ref_range_select, latch_out_hi,
        latch_out_lo, notch_rate_scale, word_rate_code, polarity_select,
        open_lead_probe};

    function automatic logic [14:0] ex(input logic [31:0] w);
        return {w[31:27], w[25:23], w[19], w[14:9]};
    endfunction : ex

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic t_sysreset();
        chk(flds, 0);
        chk(word_period, 40960);
        h.wr(32'h2800_0000);
        chk(flds, ex(32'h3000_0000));
        chk(logic_reset, 1);
        h.wr(32'h0800_0000);
        chk(logic_reset, 0);
        chk(flds, ex(32'h1000_0000));
        h.rd(r);
        chk(r, 32'h1000_0000);
        h.rd(r);
        chk(r, 0);
        h.wr(32'h1000_0000);
        chk(reset_valid_flag, 0);
    endtask : t_sysreset

    task automatic t_fields();
        h.wr(32'h0B88_0600);
        chk(flds, ex(32'h0B88_0600));
        chk(word_period, 49152);
        h.rd(r);
        chk(r, 32'h0B88_0600);
        h.wr(32'h0080_0000);
        chk({latch_out_hi, latch_out_lo}, 2'b01);
        chk(input_short, 0);
    endtask : t_fields

    task automatic t_rates();
        int rt2;
        for (int i = 0; i < 10; i++)
        begin
            code = (i < 5) ? 4'(i) : 4'(i + 3);
            // twice the rate in Sps, halving per code step
            rt2 = (code[3] ? 7680 : 240) >> code[2:0];
            p = PERIOD_W'(2 * MCLK_HZ / rt2);
            h.wr({17'h0_0000, code, 11'h000});
            chk(word_period, p);
            chk(rate_code_valid, 1);
            chk(first_period, 22'(p) * 4);
        end
    endtask : t_rates

    task automatic t_power();
        h.wr(32'h4000_0000);
        chk(power_mode, PM_STANDBY);
        chk(pw, 4'hC);
        h.wr(32'hC000_0000);
        chk(power_mode, PM_SLEEP);
        chk(pw, 4'h0);
        h.wr(32'h0000_0000);
        chk(power_mode, PM_WAKE);
        repeat (200) @(negedge core_clk);
        chk(power_mode, PM_NORMAL);
        chk(pw, 4'hF);
        ext_clock_sel = 1'b1; // no start-up wait with external clock
        h.wr(32'hC000_0000);
        h.wr(32'h0000_0000);
        chk(power_mode, PM_NORMAL);
    endtask : t_power

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        rstn = 1'b0;
        ext_clock_sel = 1'b0;
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        repeat (3) @(negedge link_clk);
        t_sysreset();
        t_fields();
        t_rates();
        t_power();
        end_sim();
    end
endmodule : test_adc_config_control_register
